// >>> src/adc_conversion_sequencer.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// RQ1: software trigger starts on channel write
// RQ2: hardware trigger event starts a conversion
// RQ3: continuous mode relaunches after each transfer
// RQ4: complete flag set at transfer, irq gated
// RQ5: 10-bit half-read blocks and discards result
// RQ6: failed compare single conversion just stops
// RQ7: other blocked transfers start another conversion
// RQ8: software avoids result reads mid-conversion
// RQ9: control one write aborts, maybe restarts
// RQ10: mode register writes abort conversion
// RQ11: reset or stop without async aborts
// RQ12: abort keeps results, reset clears them
// RQ13: idle until started, async clock gated
// RQ14: sample short or long, then approximate
// RQ15: first conversion 20/23/40/43 plus 5 bus
// RQ16: async clock adds 5 us startup
// RQ17: later continuous conversions 17/20/37/40 cycles
// RQ18: continuous timing needs adequate bus clock
// RQ19: compare transfers result minus compare value
// RQ20: greater select picks ge, else lt
// RQ21: false compare leaves flag and results
// RQ22: wait mode never stops conversions
// RQ23: converter off in reset or channel ones
// RQ24: trigger rising edge, ignored when busy
// RQ25: high read locks, low read unlocks
module adc_conversion_sequencer #(
  parameter int ASYNC_DIV = 4
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger, clocks and mode inputs
  input wire logic hw_trigger_input,
  input wire logic alt_clk_in,
  input wire logic stop_mode,
  // analog front end
  input wire logic [9:0] analog_result,
  output logic [4:0] channel_out,
  output logic sample_active,
  output logic converter_enable,
  output logic async_clk_enable,
  output logic low_power_out,
  output logic conversion_irq
);
  import adc_seq_pkg::*;

  state_t st_r, st_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic conversion_complete_flag_r, complete_irq_enable_r, continuous_convert_enable_r, trg_r, cmpen_r, gt_r, lock_r;
  logic [4:0] ch_r;
  logic [7:0] cfg_r, cvl_r;
  logic [1:0] cvh_r;
  logic [9:0] res_r, held_r;
  logic [9:0] ana_s1_r, ana_s2_r;
  logic trig_s1_r, trig_s2_r, trig_s3_r;
  logic alt_s1_r, alt_s2_r, alt_s3_r;
  logic half_r;
  logic [2:0] div_r;
  logic [7:0] osc_r;
  logic [31:0] rdata_nxt;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r, samp_r, conv_en_r, async_en_r;
  logic [4:0] chan_r;

  // apb decode; reads and writes act only at the completing access edge
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_r;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_sc1 = paddr == OFS_SC1;
  wire hit_sc2 = paddr == OFS_SC2;
  wire hit_cfg = paddr == OFS_CFG;
  wire hit_rh = paddr == OFS_RH;
  wire hit_rl = paddr == OFS_RL;
  wire hit_cvh = paddr == OFS_CVH;
  wire hit_cvl = paddr == OFS_CVL;
  wire mapped = hit_sc1 | hit_sc2 | hit_cfg | hit_rh | hit_rl | hit_cvh | hit_cvl;
  wire wr_sc1 = wr & hit_sc1;
  wire wr_sc2 = wr & hit_sc2;
  wire wr_cfg = wr & hit_cfg;
  wire wr_cvh = wr & hit_cvh;
  wire wr_cvl = wr & hit_cvl;
  wire rd_rh = rd & hit_rh;
  wire rd_rl = rd & hit_rl;

  // configuration fields
  wire mode10 = cfg_r[CFG_MODE_LO +: 2] == MODE_10;
  wire long_smp = cfg_r[CFG_LSMP];
  wire [1:0] clk_sel = cfg_r[1:0];
  wire [1:0] div_sel = cfg_r[CFG_DIV_LO +: 2];
  wire idle = st_r == S_IDLE;
  wire [9:0] sample_len = long_smp ? SAMPLE_LONG_CONVERSION_CLOCK : SAMPLE_SHORT_CONVERSION_CLOCK; // RQ14
  wire [9:0] sar_len = mode10 ? SAR10_CONVERSION_CLOCK : SAR8_CONVERSION_CLOCK; // RQ15 RQ17

  // aborts and starts; stop without the async clock aborts the conversion to idle
  // with the async clock selected a stop leaves conversions running
  wire stop_block = stop_mode & (clk_sel != CLK_ASYNC);
  wire mode_wr = wr_sc2 | wr_cfg | wr_cvh | wr_cvl; // RQ10
  wire abort_any = wr_sc1 | mode_wr | (stop_block & ~idle); // RQ9 RQ11
  wire sw_start = wr_sc1 & ~trg_r & (pwdata[4:0] != CH_OFF) & ~stop_block; // RQ1 RQ9
  wire trig_edge = trig_s2_r & ~trig_s3_r;
  wire hw_start = trig_edge & trg_r & idle & (ch_r != CH_OFF) & ~stop_block; // RQ2 RQ24

  // conversion clock: source select then power-of-two divide
  wire alt_tick = alt_s2_r & ~alt_s3_r;
  wire osc_tick = async_en_r & (osc_r == 8'(ASYNC_DIV - 1));
  wire src_tick = (clk_sel == CLK_ASYNC) ? osc_tick :
                  (clk_sel == CLK_ALT) ? alt_tick :
                  (clk_sel == CLK_BUS2) ? half_r : 1'b1;
  wire [2:0] div_max = (div_sel == 2'h0) ? 3'h0 :
                       (div_sel == 2'h1) ? 3'h1 :
                       (div_sel == 2'h2) ? 3'h3 : 3'h7;
  // every tick is a whole pclk, so sample time holds whatever the divide
  wire conversion_clock = src_tick & (div_r == div_max); // RQ18
  wire [2:0] div_nxt = idle ? 3'h0 : (conversion_clock ? 3'h0 : (src_tick ? div_r + 3'h1 : div_r));
  wire [7:0] osc_nxt = (~async_en_r | osc_tick) ? 8'h00 : osc_r + 8'h01;
  wire cnt_zero = cnt_r == 10'h000;

  // compare path: add two's complement of the compare value
  wire [9:0] raw = mode10 ? held_r : {2'b00, held_r[9:2]};
  wire [9:0] cv = mode10 ? {cvh_r, cvl_r} : {2'b00, cvl_r};
  wire [10:0] diff = {1'b0, raw} + {1'b0, ~cv} + 11'h001; // RQ19
  wire raw_ge = diff[10];
  wire cond = gt_r ? raw_ge : ~raw_ge; // RQ20
  wire [9:0] cmp_data = mode10 ? diff[9:0] : {2'b00, diff[7:0]};
  wire [9:0] xfer_data = cmpen_r ? cmp_data : raw; // RQ19

  // completion decision, taken on the last approximation tick;
  // no extra cycle, so back-to-back conversions keep the tick count
  wire done = (st_r == S_CONVERT) & conversion_clock & cnt_zero;
  wire cmp_fail = cmpen_r & ~cond;
  wire blocked = mode10 & lock_r;
  wire xfer = done & ~cmp_fail & ~blocked & ~abort_any; // RQ4 RQ5 RQ21
  wire again = continuous_convert_enable_r | (blocked & ~cmp_fail); // RQ3 RQ6 RQ7

  // status flags; a new completion beats a clear in the same cycle
  // reading the low byte acknowledges the flag as well
  wire conversion_complete_flag_clr = wr_sc1 | rd_rl;
  wire conversion_complete_flag_nxt = xfer | (conversion_complete_flag_r & ~conversion_complete_flag_clr); // RQ4
  wire lock_nxt = (rd_rh & mode10) | (lock_r & ~rd_rl); // RQ25
  // results move only on a completed transfer; aborts leave them
  wire [9:0] res_nxt = xfer ? xfer_data : res_r; // RQ12
  wire complete_irq_enable_nxt = wr_sc1 ? pwdata[SC1_COMPLETE_IRQ_ENABLE] : complete_irq_enable_r;
  wire [4:0] ch_nxt = wr_sc1 ? pwdata[4:0] : ch_r;
  wire [9:0] held_nxt = (st_r == S_SAMPLE) & conversion_clock & cnt_zero ? ana_s2_r : held_r;

  // sequencer; wait mode has no input here, so conversions simply run on
  always_comb begin // RQ22
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (abort_any) begin
      st_nxt = sw_start ? S_START : S_IDLE;
      cnt_nxt = BUS_OVERHEAD_CYC - 10'h001;
    end else begin
      case (st_r)
        S_IDLE: begin // RQ13
          if (hw_start) begin
            st_nxt = S_START;
            cnt_nxt = BUS_OVERHEAD_CYC - 10'h001;
          end
        end
        // five bus cycles of start overhead ahead of the first tick
        S_START: begin // RQ15
          if (!cnt_zero) begin
            cnt_nxt = cnt_r - 10'h001;
          end else if (clk_sel == CLK_ASYNC) begin
            st_nxt = S_WARM;
            cnt_nxt = ASYNC_START_CYC - 10'h001;
          end else begin
            st_nxt = S_SETUP;
            cnt_nxt = FIRST_SETUP_CONVERSION_CLOCK - 10'h001;
          end
        end
        S_WARM: begin // RQ16
          if (!cnt_zero) begin
            cnt_nxt = cnt_r - 10'h001;
          end else begin
            st_nxt = S_SETUP;
            cnt_nxt = FIRST_SETUP_CONVERSION_CLOCK - 10'h001;
          end
        end
        S_SETUP: begin
          if (conversion_clock && cnt_zero) begin
            st_nxt = S_SAMPLE;
            cnt_nxt = sample_len - 10'h001;
          end else if (conversion_clock) begin
            cnt_nxt = cnt_r - 10'h001;
          end
        end
        S_SAMPLE: begin // RQ14
          if (conversion_clock && cnt_zero) begin
            st_nxt = S_CONVERT;
            cnt_nxt = sar_len - 10'h001;
          end else if (conversion_clock) begin
            cnt_nxt = cnt_r - 10'h001;
          end
        end
        // the transfer edge goes straight back to sampling when relaunching
        S_CONVERT: begin // RQ3 RQ7 RQ17
          if (done && again) begin
            st_nxt = S_SAMPLE;
            cnt_nxt = sample_len - 10'h001;
          end else if (done) begin
            st_nxt = S_IDLE;
          end else if (conversion_clock) begin
            cnt_nxt = cnt_r - 10'h001;
          end
        end
        default: begin
          st_nxt = S_IDLE;
          cnt_nxt = 10'h000;
        end
      endcase
    end
  end

  // read mux, sampled in the setup cycle so prdata comes from a flop
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (1'b1)
      hit_sc1: rdata_nxt[7:0] = {conversion_complete_flag_r, complete_irq_enable_r, continuous_convert_enable_r, ch_r};
      hit_sc2: rdata_nxt[7:0] = {~idle, trg_r, cmpen_r, gt_r, 4'h0};
      hit_cfg: rdata_nxt[7:0] = cfg_r;
      hit_rh: rdata_nxt[7:0] = {6'h00, res_r[9:8]};
      hit_rl: rdata_nxt[7:0] = res_r[7:0];
      hit_cvh: rdata_nxt[7:0] = {6'h00, cvh_r};
      hit_cvl: rdata_nxt[7:0] = cvl_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // two-flop synchronisers; the edge detectors compare the second stage with a third flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {trig_s1_r, trig_s2_r, trig_s3_r} <= 3'h0;
      {alt_s1_r, alt_s2_r, alt_s3_r} <= 3'h0;
      ana_s1_r <= 10'h000;
      ana_s2_r <= 10'h000;
    end else begin
      {trig_s1_r, trig_s2_r, trig_s3_r} <= {hw_trigger_input, trig_s1_r, trig_s2_r};
      {alt_s1_r, alt_s2_r, alt_s3_r} <= {alt_clk_in, alt_s1_r, alt_s2_r};
      ana_s1_r <= analog_result;
      ana_s2_r <= ana_s1_r;
    end
  end

  // sequencer and clock divider state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE; // RQ11
      cnt_r <= 10'h000;
      div_r <= 3'h0;
      osc_r <= 8'h00;
      half_r <= 1'b0;
      held_r <= 10'h000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      osc_r <= osc_nxt;
      half_r <= ~half_r;
      held_r <= held_nxt;
    end
  end

  // software registers and result holding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_r <= CH_RST;
      {conversion_complete_flag_r, complete_irq_enable_r, continuous_convert_enable_r} <= 3'h0;
      {trg_r, cmpen_r, gt_r} <= 3'h0;
      cfg_r <= CFG_RST;
      cvh_r <= CVH_RST;
      cvl_r <= CVL_RST;
      res_r <= RES_RST; // RQ12
      lock_r <= 1'b0;
    end else begin
      ch_r <= ch_nxt;
      conversion_complete_flag_r <= conversion_complete_flag_nxt;
      complete_irq_enable_r <= complete_irq_enable_nxt;
      continuous_convert_enable_r <= wr_sc1 ? pwdata[SC1_CONTINUOUS_CONVERT_ENABLE] : continuous_convert_enable_r;
      {trg_r, cmpen_r, gt_r} <= wr_sc2 ? pwdata[SC2_TRG:SC2_GT] : {trg_r, cmpen_r, gt_r};
      cfg_r <= wr_cfg ? pwdata[7:0] : cfg_r;
      cvh_r <= wr_cvh ? pwdata[1:0] : cvh_r;
      cvl_r <= wr_cvl ? pwdata[7:0] : cvl_r;
      res_r <= res_nxt;
      lock_r <= lock_nxt; // RQ5
    end
  end

  // registered apb answer: ready in every access cycle, error if unmapped
  // unmapped addresses read zero and drop writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= setup ? rdata_nxt : prdata_r;
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
    end
  end

  // front-end controls; async oscillator only runs while converting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      samp_r <= 1'b0;
      conv_en_r <= 1'b0; // RQ23
      async_en_r <= 1'b0;
      chan_r <= CH_RST;
    end else begin
      irq_r <= conversion_complete_flag_nxt & complete_irq_enable_nxt; // RQ4 RQ22
      samp_r <= st_nxt == S_SAMPLE;
      conv_en_r <= ch_nxt != CH_OFF; // RQ23
      async_en_r <= (clk_sel == CLK_ASYNC) & (st_nxt != S_IDLE); // RQ13
      chan_r <= ch_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conversion_irq = irq_r;
  assign sample_active = samp_r;
  assign converter_enable = conv_en_r;
  assign async_clk_enable = async_en_r;
  assign channel_out = chan_r;
  assign low_power_out = cfg_r[CFG_LPC];
endmodule

// >>> src/adc_seq_pkg.sv
package adc_seq_pkg;
  // register byte offsets on the apb window
  localparam logic [7:0] OFS_SC1 = 8'h00;
  localparam logic [7:0] OFS_SC2 = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_RH = 8'h0c;
  localparam logic [7:0] OFS_RL = 8'h10;
  localparam logic [7:0] OFS_CVH = 8'h14;
  localparam logic [7:0] OFS_CVL = 8'h18;
  // field positions
  localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
  localparam int SC1_COMPLETE_IRQ_ENABLE = 6;
  localparam int SC1_CONTINUOUS_CONVERT_ENABLE = 5;
  localparam int SC2_ACT = 7;
  localparam int SC2_TRG = 6;
  localparam int SC2_CMPEN = 5;
  localparam int SC2_GT = 4;
  localparam int CFG_LPC = 7;
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE_LO = 2;
  // values after reset
  localparam logic [4:0] CH_RST = 5'h1f;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] CVH_RST = 2'h0;
  localparam logic [7:0] CVL_RST = 8'h00;
  localparam logic [9:0] RES_RST = 10'h000;
  // encodings
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] CLK_BUS2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  // timing, conversion clock cycles unless named otherwise
  localparam int PCLK_MHZ = 200;
  localparam int ASYNC_START_US = 5;
  localparam logic [9:0] ASYNC_START_CYC = 10'(ASYNC_START_US * PCLK_MHZ);
  localparam logic [9:0] BUS_OVERHEAD_CYC = 10'h005;
  localparam logic [9:0] FIRST_SETUP_CONVERSION_CLOCK = 10'h003;
  localparam logic [9:0] SAMPLE_SHORT_CONVERSION_CLOCK = 10'h004;
  localparam logic [9:0] SAMPLE_LONG_CONVERSION_CLOCK = 10'h018;
  localparam logic [9:0] SAR8_CONVERSION_CLOCK = 10'h00d;
  localparam logic [9:0] SAR10_CONVERSION_CLOCK = 10'h010;
  // sequencer states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_START = 7'h02,
    S_WARM = 7'h04,
    S_SETUP = 7'h08,
    S_SAMPLE = 7'h10,
    S_CONVERT = 7'h20,
    S_DONE = 7'h40
  } state_t;
endpackage

// >>> test/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
  import adc_seq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic stop_mode = 1'b0;
  logic fire = 1'b0;
  logic [9:0] level = 10'h2a8;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, trig, alt, lpc, conv_en, irq;
  logic [9:0] ana;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  // small async divider keeps any async run short
  adc_conversion_sequencer #(.ASYNC_DIV(2)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_trigger_input(trig),
    .alt_clk_in(alt), .stop_mode(stop_mode), .analog_result(ana), .channel_out(),
    .sample_active(), .converter_enable(conv_en), .async_clk_enable(),
    .low_power_out(lpc), .conversion_irq(irq));
  adc_front_model front (.pclk(pclk), .presetn(presetn), .level(level), .fire(fire),
    .converter_enable(conv_en), .analog_result(ana), .hw_trigger_input(trig),
    .alt_clk_in(alt));
  // 200 mhz bus clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // one transfer; request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, rdat);
  endtask
  // polls only the status, never the results, while converting
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_SC1, 32'h0);
      n++;
    end while (rdat[SC1_CONVERSION_COMPLETE_FLAG] !== 1'b1 && n < 200);
    chk("complete flag", 32'h1, {31'h0, rdat[SC1_CONVERSION_COMPLETE_FLAG]});
  endtask
  // edges from a write edge until the irq pin is seen high there
  task automatic lat(input string s, input int x);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq !== 1'b1 && n < 200);
    chk(s, x, n);
  endtask
  task automatic idle();
    repeat (100) @(posedge pclk);
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard, far above the roughly one thousand cycles needed
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    chk("enable in reset", 32'h0, {31'h0, conv_en});
    presetn <= 1'b1;
    rc(OFS_SC1, 32'h1f);
    rc(OFS_RL, 32'h0);
    rc(8'h1c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    // single 8-bit software start with irq enabled
    wr(OFS_SC1, 32'h41);
    // 20 ticks plus 5 bus cycles, seen one edge after the transfer
    lat("first 8-bit time", 26);
    wait_flag();
    chk("irq", 32'h1, {31'h0, irq});
    rc(OFS_RL, 32'haa);
    // compare true, then false
    wr(OFS_CVL, 32'h10);
    wr(OFS_SC2, 32'h30);
    level <= 10'h080;
    wr(OFS_SC1, 32'h01);
    wait_flag();
    rc(OFS_RL, 32'h10);
    wr(OFS_SC2, 32'h20);
    wr(OFS_SC1, 32'h01);
    idle();
    rc(OFS_SC1, 32'h01);
    rc(OFS_RL, 32'h10);
    rc(OFS_SC2, 32'h20);
    // 10-bit half read blocks the next transfer
    wr(OFS_SC2, 32'h0);
    wr(OFS_CFG, 32'h98);
    rc(OFS_CFG, 32'h98);
    chk("low power", 32'h1, {31'h0, lpc});
    level <= 10'h2a8;
    wr(OFS_SC1, 32'h41);
    // 43 ticks plus 5 bus cycles with long sampling
    lat("first 10-bit long time", 49);
    wait_flag();
    rc(OFS_RH, 32'h2);
    level <= 10'h155;
    wr(OFS_SC1, 32'h01);
    idle();
    rc(OFS_SC1, 32'h01);
    rc(OFS_SC2, 32'h80);
    rc(OFS_RL, 32'ha8);
    wait_flag();
    rc(OFS_RH, 32'h1);
    // half read pending, failed single compare just stops
    wr(OFS_SC2, 32'h20);
    wr(OFS_SC1, 32'h01);
    idle();
    rc(OFS_SC2, 32'h20);
    rc(OFS_SC1, 32'h01);
    wr(OFS_SC2, 32'h0);
    rc(OFS_RL, 32'h55);
    // aborts by a mode write and by stop; a finished run would show 0xfc, then 0xff
    level <= 10'h3fc;
    wr(OFS_SC1, 32'h01);
    wr(OFS_CFG, 32'h00);
    idle();
    rc(OFS_SC1, 32'h01);
    rc(OFS_SC2, 32'h0);
    rc(OFS_RL, 32'h55);
    wr(OFS_SC1, 32'h01);
    stop_mode <= 1'b1;
    idle();
    stop_mode <= 1'b0;
    rc(OFS_SC1, 32'h01);
    rc(OFS_SC2, 32'h0);
    rc(OFS_RL, 32'h55);
    level <= 10'h155;
    // hardware trigger: a channel write alone starts nothing
    wr(OFS_SC2, 32'h40);
    wr(OFS_SC1, 32'h01);
    idle();
    rc(OFS_SC1, 32'h01);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    wait_flag();
    rc(OFS_RL, 32'h55);
    // continuous run, then channel off
    wr(OFS_SC2, 32'h0);
    wr(OFS_SC1, 32'h21);
    wait_flag();
    rc(OFS_RL, 32'h55);
    wait_flag();
    wr(OFS_SC1, 32'h1f);
    repeat (4) @(posedge pclk);
    chk("enable off", 32'h0, {31'h0, conv_en});
    rc(OFS_SC2, 32'h0);
    finish_test();
  end
endmodule
bind adc_conversion_sequencer adc_seq_checker u_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .stop_mode(stop_mode), .channel_out(channel_out),
  .sample_active(sample_active), .converter_enable(converter_enable),
  .async_clk_enable(async_clk_enable));

// >>> test/adc_front_model.sv
`timescale 1ns/1ps
// analog source, trigger pin and alternate clock beyond the block
module adc_front_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench requests
  input wire logic [9:0] level,
  input wire logic fire,
  input wire logic converter_enable,
  // pins toward the block
  output logic [9:0] analog_result,
  output logic hw_trigger_input,
  output logic alt_clk_in
);
  logic [2:0] hold_r;
  // a disabled front end shows junk, never the last good level
  assign analog_result = converter_enable ? level : ~level;
  assign hw_trigger_input = |hold_r;
  // pulse held long enough to pass the two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 3'h0;
      alt_clk_in <= 1'b0;
    end else begin
      hold_r <= fire ? 3'h7 : hold_r - {2'h0, |hold_r};
      alt_clk_in <= ~alt_clk_in;
    end
  end
endmodule

// >>> test/adc_seq_checker.sv
`timescale 1ns/1ps
// apb answer timing and front end gating, seen from the top ports
module adc_seq_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // mode and front end
  input wire logic stop_mode,
  input wire logic [4:0] channel_out,
  input wire logic sample_active,
  input wire logic converter_enable,
  input wire logic async_clk_enable
);
  import adc_seq_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the two steps of a transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  // zero wait states, and ready never outside an access
  a_pready_after_setup: assert property (setup_s |=> pready)
    else $error("ready missing after setup");
  a_pready_in_access: assert property (pready |-> access_s and $past(psel && !penable))
    else $error("ready outside access");
  a_slverr_unmapped: assert property (setup_s and paddr > OFS_CVL |=> pslverr)
    else $error("no error on unmapped address");
  a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // the converter stays off while no channel is selected
  a_chan_off_disabled: assert property (
    $stable(channel_out) && channel_out == CH_OFF |-> !converter_enable)
    else $error("converter on with channel off");
  a_sample_needs_enable: assert property (sample_active |-> converter_enable)
    else $error("sampling while disabled");
  a_async_gate: assert property (async_clk_enable |-> converter_enable)
    else $error("async clock on while disabled");
  // stop without the async clock leaves nothing sampling
  a_stop_no_sample: assert property (
    (stop_mode && !async_clk_enable) [*3] |-> !sample_active)
    else $error("sampling in stop");
endmodule
